// >>> src/ecat_status_pkg.sv
/*
  package for the fieldbus slave state and indicator block: state codes,
  area limits and indicator pattern timing.
  assumes a 100 MHz mclk; no module content here.
*/
package ecat_status_pkg;

  // =====================================================================
  // application states driven by the bus master
  typedef enum logic [1:0] {
    st_init,
    st_preop,
    st_safeop,
    st_op
  } app_state_t;

  // =====================================================================
  // error indicator causes
  typedef enum logic [2:0] {
    err_none,
    err_config,
    err_local,
    err_watchdog,
    err_comm
  } err_cause_t;

  // =====================================================================
  // process data areas
  localparam int unsigned area_max_bytes = 254;
  localparam int unsigned area_len_w = 8;

  // =====================================================================
  // timing
  localparam int unsigned clk_mhz = 100;
  // pattern slot in microseconds: blink half period and flash length
  localparam int unsigned slot_us = 200000;
  localparam int unsigned slot_cycles = slot_us * clk_mhz;
  // flicker half period in microseconds
  localparam int unsigned flick_us = 50000;
  localparam int unsigned flick_cycles = flick_us * clk_mhz;
  // activity stretch after the last data exchange
  localparam int unsigned act_hold_us = 100000;
  localparam int unsigned act_hold_cycles = act_hold_us * clk_mhz;
  localparam int unsigned cnt_w = 32;
  // slots in one flash frame: on,off,on,off, then long off
  localparam logic [3:0] frame_slots = 4'ha;

endpackage

// >>> src/pattern_gen.sv
/*
  pattern generator: free-running slot counter giving the blink,
  single-flash and double-flash waveforms, plus a separate flicker counter, shared by all indicators.
  assumes one clock mclk and asynchronous active-low reset.
*/
`timescale 1ns/1ps
module pattern_gen #(
  parameter int unsigned slot_cycles = ecat_status_pkg::slot_cycles,
  parameter int unsigned flick_cycles = ecat_status_pkg::flick_cycles
) (
  // clock and reset
  input wire logic mclk,
  input wire logic reset_n,
  // waveforms
  output logic blink,
  output logic flicker,
  output logic flash1,
  output logic flash2
);

  logic [ecat_status_pkg::cnt_w-1:0] slot_cnt_r;
  logic [ecat_status_pkg::cnt_w-1:0] flick_cnt_r;
  logic [3:0] slot_r;

  // =====================================================================
  // counter driven patterns
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      slot_cnt_r <= '0;
      slot_r <= 4'h0;
    end else if (slot_cnt_r == slot_cycles - 1) begin
      slot_cnt_r <= '0;
      slot_r <= (slot_r == ecat_status_pkg::frame_slots - 4'h1) ?
                4'h0 : slot_r + 4'h1;
    end else begin
      slot_cnt_r <= slot_cnt_r + 1'b1;
    end
  end

  // flicker runs on its own faster counter
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      flick_cnt_r <= '0;
      flicker <= 1'b0;
    end else if (flick_cnt_r == flick_cycles - 1) begin
      flick_cnt_r <= '0;
      flicker <= !flicker;
    end else begin
      flick_cnt_r <= flick_cnt_r + 1'b1;
    end
  end

  // outputs registered so they follow the slot with one cycle delay
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      blink <= 1'b0;
      flash1 <= 1'b0;
      flash2 <= 1'b0;
    end else begin
      blink <= !slot_r[0];
      flash1 <= (slot_r == 4'h0);
      flash2 <= (slot_r == 4'h0) || (slot_r == 4'h2);
    end
  end

endmodule

// >>> src/ecat_slave_status.sv
/*
  fieldbus slave state tracker and indicator driver: gates process data
  by application state, checks area sizes, drives link, run and error
  indicators.
  assumes the bus master state request and the local controller setup
  inputs are synchronous to mclk; indicators are active high.
*/
// Notes on behaviour
// - init: no process inputs or outputs exchanged
// - preop: communicate, inputs and outputs inactive
// - safeop: accept bus data, outputs inactive
// - op: inputs and outputs both active
// - one input, one output area, max 254
// - link led: off, steady, flicker on activity
// - run led encodes state, red on exception
// - error led encodes error cause patterns
// - serious fault: run and error steady red
// - only link led driven per connector
`timescale 1ns/1ps
module ecat_slave_status #(
  parameter int unsigned slot_cycles = ecat_status_pkg::slot_cycles,
  parameter int unsigned flick_cycles = ecat_status_pkg::flick_cycles,
  parameter int unsigned act_hold_cycles = ecat_status_pkg::act_hold_cycles
) (
  // clock and reset
  input wire logic mclk,
  input wire logic reset_n,
  // state request from the bus master
  input wire logic state_req_valid,
  input wire ecat_status_pkg::app_state_t state_req,
  // local controller setup
  input wire logic cfg_valid,
  input wire logic [ecat_status_pkg::area_len_w-1:0] cfg_in_len,
  input wire logic [ecat_status_pkg::area_len_w-1:0] cfg_out_len,
  // error sources
  input wire logic err_local_evt,
  input wire logic err_watchdog,
  input wire logic err_comm,
  input wire logic exception,
  input wire logic fatal_fault,
  // per port link status
  input wire logic [1:0] port_link,
  input wire logic [1:0] port_rx_evt,
  // process data strobes
  input wire logic bus_data_evt,
  input wire logic out_data_evt,
  // state and gating
  output ecat_status_pkg::app_state_t app_state,
  output logic cfg_done,
  output logic inputs_active,
  output logic outputs_active,
  output logic bus_comm_en,
  output logic in_data_take,
  output logic out_data_take,
  // indicators
  output logic [1:0] led_link_green,
  output logic [1:0] led_aux_a,
  output logic [1:0] led_aux_b,
  output logic led_run_green,
  output logic led_run_red,
  output logic led_err_red
);

  // =====================================================================
  // pattern source
  logic blink, flicker, flash1, flash2;

  pattern_gen #(
    .slot_cycles(slot_cycles),
    .flick_cycles(flick_cycles)
  ) u_pattern (
    .mclk(mclk),
    .reset_n(reset_n),
    .blink(blink),
    .flicker(flicker),
    .flash1(flash1),
    .flash2(flash2)
  );

  // =====================================================================
  // setup of the data areas
  logic cfg_ok_r, cfg_bad_r;

  function automatic logic len_ok(
    input logic [ecat_status_pkg::area_len_w-1:0] len
  );
    len_ok = (len <= ecat_status_pkg::area_len_w'(
             ecat_status_pkg::area_max_bytes));
  endfunction

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      cfg_ok_r <= 1'b0;
      cfg_bad_r <= 1'b0;
    end else if (cfg_valid) begin
      cfg_ok_r <= len_ok(cfg_in_len) && len_ok(cfg_out_len);
      cfg_bad_r <= !(len_ok(cfg_in_len) && len_ok(cfg_out_len));
    end
  end

  // =====================================================================
  // application state; beyond init only once the areas are set up
  ecat_status_pkg::app_state_t state_r;
  logic state_chg_r;

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      state_r <= ecat_status_pkg::st_init;
      state_chg_r <= 1'b0;
    end else begin
      state_chg_r <= 1'b0;
      if (state_req_valid && (cfg_ok_r ||
          state_req == ecat_status_pkg::st_init)) begin
        state_r <= state_req;
        state_chg_r <= (state_req != state_r);
      end
    end
  end

  // =====================================================================
  // gating of process data by state
  logic in_en, out_en, comm_en;

  always_comb begin
    in_en = 1'b0;
    out_en = 1'b0;
    comm_en = 1'b0;
    case (state_r)
      ecat_status_pkg::st_init: comm_en = 1'b0;
      ecat_status_pkg::st_preop: comm_en = 1'b1;
      ecat_status_pkg::st_safeop: begin
        comm_en = 1'b1;
        in_en = 1'b1;
      end
      ecat_status_pkg::st_op: begin
        comm_en = 1'b1;
        in_en = 1'b1;
        out_en = 1'b1;
      end
      default: comm_en = 1'b0;
    endcase
  end

  // registered gating and data strobes
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      app_state <= ecat_status_pkg::st_init;
      cfg_done <= 1'b0;
      inputs_active <= 1'b0;
      outputs_active <= 1'b0;
      bus_comm_en <= 1'b0;
      in_data_take <= 1'b0;
      out_data_take <= 1'b0;
    end else begin
      app_state <= state_r;
      cfg_done <= cfg_ok_r;
      inputs_active <= in_en;
      outputs_active <= out_en;
      bus_comm_en <= comm_en;
      in_data_take <= bus_data_evt && in_en;
      out_data_take <= out_data_evt && out_en;
    end
  end

  // =====================================================================
  // activity stretch per port, so flicker is visible
  logic [1:0] act_r;
  logic [ecat_status_pkg::cnt_w-1:0] act_cnt_r [2];

  for (genvar p = 0; p < 2; p++) begin : g_port
    always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
        act_cnt_r[p] <= '0;
        act_r[p] <= 1'b0;
      end else if (port_rx_evt[p] && port_link[p]) begin
        act_cnt_r[p] <= ecat_status_pkg::cnt_w'(act_hold_cycles);
        act_r[p] <= 1'b1;
      end else if (act_cnt_r[p] != '0) begin
        act_cnt_r[p] <= act_cnt_r[p] - 1'b1;
        act_r[p] <= (act_cnt_r[p] != 1);
      end else begin
        act_r[p] <= 1'b0;
      end
    end

    always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
        led_link_green[p] <= 1'b0;
        led_aux_a[p] <= 1'b0;
        led_aux_b[p] <= 1'b0;
      end else begin
        led_link_green[p] <= port_link[p] && (!act_r[p] || flicker);
        led_aux_a[p] <= 1'b0;
        led_aux_b[p] <= 1'b0;
      end
    end
  end

  // =====================================================================
  // error cause; a local error is kept until the next state change into init
  logic local_err_r;
  ecat_status_pkg::err_cause_t err_cause;

  // hold local error for display; set wins over clear
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      local_err_r <= 1'b0;
    end else if (err_local_evt) begin
      local_err_r <= 1'b1;
    end else if (state_chg_r && state_r == ecat_status_pkg::st_init) begin
      local_err_r <= 1'b0;
    end
  end

  // priority: comm, watchdog, local, config
  always_comb begin
    err_cause = ecat_status_pkg::err_none;
    if (err_comm) begin
      err_cause = ecat_status_pkg::err_comm;
    end else if (err_watchdog) begin
      err_cause = ecat_status_pkg::err_watchdog;
    end else if (local_err_r) begin
      err_cause = ecat_status_pkg::err_local;
    end else if (cfg_bad_r) begin
      err_cause = ecat_status_pkg::err_config;
    end
  end

  // =====================================================================
  // run and error indicators
  logic run_g, err_r_nxt;

  always_comb begin
    run_g = 1'b0;
    case (state_r)
      ecat_status_pkg::st_init: run_g = 1'b0;
      ecat_status_pkg::st_preop: run_g = blink;
      ecat_status_pkg::st_safeop: run_g = flash1;
      ecat_status_pkg::st_op: run_g = 1'b1;
      default: run_g = 1'b0;
    endcase
  end

  always_comb begin
    err_r_nxt = 1'b0;
    case (err_cause)
      ecat_status_pkg::err_config: err_r_nxt = blink;
      ecat_status_pkg::err_local: err_r_nxt = flash1;
      ecat_status_pkg::err_watchdog: err_r_nxt = flash2;
      ecat_status_pkg::err_comm: err_r_nxt = 1'b1;
      default: err_r_nxt = 1'b0;
    endcase
  end

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      led_run_green <= 1'b0;
      led_run_red <= 1'b0;
      led_err_red <= 1'b0;
    end else if (fatal_fault) begin
      led_run_green <= 1'b0;
      led_run_red <= 1'b1;
      led_err_red <= 1'b1;
    end else begin
      led_run_green <= exception ? 1'b0 : run_g;
      led_run_red <= exception;
      led_err_red <= err_r_nxt;
    end
  end

  // =====================================================================
  // checks
  // nothing in init
  a_init_no_data: assert property (@(posedge mclk)
    disable iff (!reset_n) app_state == ecat_status_pkg::st_init |->
      !inputs_active && !outputs_active && !in_data_take)
    else $error("data active in init");
  a_preop_gating: assert property (@(posedge mclk)
    disable iff (!reset_n) app_state == ecat_status_pkg::st_preop |->
      bus_comm_en && !inputs_active && !outputs_active)
    else $error("preop gating wrong");
  a_safeop_out_off: assert property (@(posedge mclk)
    disable iff (!reset_n) app_state == ecat_status_pkg::st_safeop |->
      inputs_active && !outputs_active && !out_data_take)
    else $error("safeop outputs active");
  a_op_all_active: assert property (@(posedge mclk)
    disable iff (!reset_n) state_r == ecat_status_pkg::st_op |=>
      inputs_active && outputs_active)
    else $error("op not fully active");
  a_area_limit: assert property (@(posedge mclk)
    disable iff (!reset_n) cfg_valid &&
      (cfg_in_len > ecat_status_pkg::area_max_bytes ||
       cfg_out_len > ecat_status_pkg::area_max_bytes) |=>
      !cfg_ok_r ##1 !cfg_done)
    else $error("oversize area accepted");
  a_link_offline: assert property (@(posedge mclk)
    disable iff (!reset_n) !port_link[0] |=> !led_link_green[0])
    else $error("link led lit offline");
  a_run_op_green: assert property (@(posedge mclk)
    disable iff (!reset_n) state_r == ecat_status_pkg::st_op &&
      !exception && !fatal_fault |=> led_run_green && !led_run_red)
    else $error("run led not green in op");
  a_err_comm_red: assert property (@(posedge mclk)
    disable iff (!reset_n) err_comm |=> led_err_red)
    else $error("error led not red on comm error");
  a_fatal_both_red: assert property (@(posedge mclk)
    disable iff (!reset_n) fatal_fault |=>
      led_run_red && led_err_red && !led_run_green)
    else $error("fatal fault not shown");
  a_aux_dark: assert property (@(posedge mclk)
    disable iff (!reset_n) ##1 (led_aux_a == 2'h0) && (led_aux_b == 2'h0))
    else $error("aux led lit");

endmodule

// >>> sim/ecat_master_model.sv
/*
  bus master model: issues application state requests and data frames
  toward the slave block.
  assumes mclk and active-low reset come from the bench.
*/
`timescale 1ns/1ps
module ecat_master_model (
  // clock and reset
  input wire logic mclk,
  input wire logic reset_n,
  // toward the slave
  output logic state_req_valid,
  output ecat_status_pkg::app_state_t state_req,
  output logic [1:0] port_rx_evt
);
  // =====================================================================
  // idle levels at time zero
  initial begin
    state_req_valid = 1'b0;
    state_req = ecat_status_pkg::st_init;
    port_rx_evt = 2'h0;
  end

  // master drives states
  // released code shows the inverse so a stale value never looks valid
  task automatic request(input ecat_status_pkg::app_state_t st);
    // bounded wait; a stuck reset shows up as a refused state later
    for (int k = 0; k < 40 && reset_n !== 1'b1; k++) @(posedge mclk);
    @(posedge mclk);
    state_req_valid <= 1'b1;
    state_req <= st;
    @(posedge mclk);
    state_req_valid <= 1'b0;
    state_req <= ecat_status_pkg::app_state_t'(~st);
  endtask

  // one data frame seen on a port
  task automatic frame(input logic p);
    @(posedge mclk);
    port_rx_evt[p] <= 1'b1;
    @(posedge mclk);
    port_rx_evt <= 2'h0;
  endtask
endmodule

// >>> sim/ecat_slave_status_tb.sv
/*
  testbench for the slave state and indicator block: walks the states,
  sizes the areas and counts indicator patterns over whole frames.
  assumes short pattern parameters: slot 4, flicker 2, activity hold 8.
*/
`timescale 1ns/1ps
module ecat_slave_status_tb;
  // =====================================================================
  // signals
  logic mclk = 1'b0;
  logic reset_n = 1'b0;
  logic state_req_valid;
  ecat_status_pkg::app_state_t state_req, app_state;
  logic [1:0] port_rx_evt;
  logic cfg_valid = 1'b0;
  logic [7:0] cfg_in_len = 8'h00;
  logic [7:0] cfg_out_len = 8'h00;
  logic err_local_evt = 1'b0;
  logic err_watchdog = 1'b0;
  logic err_comm = 1'b0;
  logic exception = 1'b0;
  logic fatal_fault = 1'b0;
  logic [1:0] port_link = 2'h0;
  logic bus_data_evt = 1'b0;
  logic out_data_evt = 1'b0;
  logic cfg_done, inputs_active, outputs_active, bus_comm_en;
  logic in_data_take, out_data_take;
  logic [1:0] led_link_green, led_aux_a, led_aux_b;
  logic led_run_green, led_run_red, led_err_red;
  logic [7:0] c_run, c_red, c_err, c_lnk;
  int n_fail = 0;
  int compares = 0;

  // =====================================================================
  // clock, design and partner
  initial forever #5 mclk = ~mclk;

  ecat_slave_status #(.slot_cycles(4), .flick_cycles(2),
    .act_hold_cycles(8)) u_ecat_slave_status (
    .mclk(mclk), .reset_n(reset_n),
    .state_req_valid(state_req_valid), .state_req(state_req),
    .cfg_valid(cfg_valid), .cfg_in_len(cfg_in_len),
    .cfg_out_len(cfg_out_len), .err_local_evt(err_local_evt),
    .err_watchdog(err_watchdog), .err_comm(err_comm),
    .exception(exception), .fatal_fault(fatal_fault),
    .port_link(port_link), .port_rx_evt(port_rx_evt),
    .bus_data_evt(bus_data_evt), .out_data_evt(out_data_evt),
    .app_state(app_state), .cfg_done(cfg_done),
    .inputs_active(inputs_active), .outputs_active(outputs_active),
    .bus_comm_en(bus_comm_en), .in_data_take(in_data_take),
    .out_data_take(out_data_take), .led_link_green(led_link_green),
    .led_aux_a(led_aux_a), .led_aux_b(led_aux_b),
    .led_run_green(led_run_green), .led_run_red(led_run_red),
    .led_err_red(led_err_red));

  ecat_master_model u_ecat_master_model (
    .mclk(mclk), .reset_n(reset_n), .state_req_valid(state_req_valid),
    .state_req(state_req), .port_rx_evt(port_rx_evt));

  // =====================================================================
  // shared tasks
  task automatic cmp(input string nm, input logic [7:0] e,
                     input logic [7:0] g);
    compares++;
    if (g !== e) begin
      n_fail++;
      $display("[ERR] %s expected %0h seen %0h", nm, e, g);
    end
  endtask

  // count lit cycles; a whole frame of 40 makes counts phase-free
  task automatic count(input int n);
    c_run = 8'h00;
    c_red = 8'h00;
    c_err = 8'h00;
    c_lnk = 8'h00;
    repeat (2) @(posedge mclk);
    repeat (n) begin
      @(posedge mclk);
      #1;
      c_run += led_run_green;
      c_red += led_run_red;
      c_err += led_err_red;
      c_lnk += led_link_green[0];
    end
  endtask

  task automatic set_cfg(input logic [7:0] il, input logic [7:0] ol);
    @(posedge mclk);
    cfg_valid <= 1'b1;
    cfg_in_len <= il;
    cfg_out_len <= ol;
    @(posedge mclk);
    cfg_valid <= 1'b0;
    repeat (2) @(posedge mclk);
    #1;
  endtask

  task automatic goto(input ecat_status_pkg::app_state_t st);
    u_ecat_master_model.request(st);
    repeat (2) @(posedge mclk);
    #1;
  endtask

  // levels, then one data strobe of each kind
  task automatic gate(input logic c, input logic i, input logic o);
    cmp("bus_comm_en", c, bus_comm_en);
    cmp("inputs_active", i, inputs_active);
    cmp("outputs_active", o, outputs_active);
    @(posedge mclk);
    bus_data_evt <= 1'b1;
    out_data_evt <= 1'b1;
    @(posedge mclk);
    bus_data_evt <= 1'b0;
    out_data_evt <= 1'b0;
    #1;
    cmp("in_data_take", i, in_data_take);
    cmp("out_data_take", o, out_data_take);
  endtask

  task automatic close_out();
    $display("compares %0d n_fail %0d", compares, n_fail);
    if (n_fail == 0 && compares > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  // =====================================================================
  // scenarios
  task automatic t_refuse();
    cmp("app_state_rst", ecat_status_pkg::st_init, app_state);
    goto(ecat_status_pkg::st_op);
    cmp("op_before_cfg", ecat_status_pkg::st_init, app_state);
    set_cfg(8'h04, 8'hff);
    cmp("cfg_done_out_255", 8'h00, cfg_done);
    set_cfg(8'hff, 8'h04);
    cmp("cfg_done_255", 8'h00, cfg_done);
    goto(ecat_status_pkg::st_op);
    cmp("op_bad_cfg", ecat_status_pkg::st_init, app_state);
    count(40);
    cmp("err_blink", 8'h14, c_err);
    set_cfg(8'hfe, 8'h00);
    cmp("cfg_done_254", 8'h01, cfg_done);
    count(40);
    cmp("err_off", 8'h00, c_err);
  endtask

  task automatic t_states();
    logic [7:0] runs [4];
    runs = '{8'h00, 8'h14, 8'h04, 8'h28};
    for (int i = 0; i < 4; i++) begin
      goto(ecat_status_pkg::app_state_t'(i));
      cmp("app_state", i[7:0], app_state);
      gate(i > 0, i > 1, i > 2);
      count(40);
      cmp("run_green", runs[i], c_run);
    end
  endtask

  task automatic t_link();
    @(posedge mclk);
    port_link <= 2'h3;
    count(40);
    cmp("link_steady", 8'h28, c_lnk);
    u_ecat_master_model.frame(1'b0);
    count(6);
    cmp("link_flicker", 8'h01, c_lnk > 0 && c_lnk < 6);
    // port 1 stays steady while port 0 shows activity
    cmp("link_other", 8'h01, led_link_green[1]);
    count(40);
    cmp("link_idle", 8'h28, c_lnk);
    cmp("aux_leds", 8'h00, {led_aux_a, led_aux_b});
    @(posedge mclk);
    port_link <= 2'h0;
    count(40);
    cmp("link_off", 8'h00, c_lnk);
    cmp("link_off_p1", 8'h00, led_link_green[1]);
  endtask

  task automatic t_errors();
    @(posedge mclk);
    err_local_evt <= 1'b1;
    @(posedge mclk);
    err_local_evt <= 1'b0;
    count(40);
    cmp("err_flash1", 8'h04, c_err);
    @(posedge mclk);
    err_watchdog <= 1'b1;
    count(40);
    cmp("err_flash2", 8'h08, c_err);
    @(posedge mclk);
    err_comm <= 1'b1;
    count(40);
    cmp("err_steady", 8'h28, c_err);
    @(posedge mclk);
    err_comm <= 1'b0;
    err_watchdog <= 1'b0;
    exception <= 1'b1;
    count(40);
    cmp("run_exc_red", 8'h28, c_red);
    cmp("run_exc_grn", 8'h00, c_run);
    cmp("err_local_held", 8'h04, c_err);
    @(posedge mclk);
    exception <= 1'b0;
    fatal_fault <= 1'b1;
    count(40);
    cmp("fatal_run", 8'h28, c_red);
    cmp("fatal_err", 8'h28, c_err);
    cmp("fatal_grn", 8'h00, c_run);
    @(posedge mclk);
    fatal_fault <= 1'b0;
    goto(ecat_status_pkg::st_init);
    count(40);
    cmp("err_cleared", 8'h00, c_err);
  endtask

  // =====================================================================
  // main sequence and hang guard
  initial begin
    repeat (20) @(posedge mclk);
    reset_n <= 1'b1;
    t_refuse();
    t_states();
    t_link();
    t_errors();
    close_out();
  end

  initial begin
    repeat (100000) @(posedge mclk);
    n_fail++;
    $display("[ERR] run_time expected end seen limit");
    close_out();
  end
endmodule
